// >>> inc/aoc_pkg.sv
// Constants for the converter output test and configuration register bank.
package aoc_pkg;

    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [7:0] ADDR_CHAN_INDEX = 8'h05;
    localparam logic [7:0] ADDR_TEST = 8'h0d;
    localparam logic [7:0] ADDR_SELF_TEST = 8'h0e;
    localparam logic [7:0] ADDR_OFFSET = 8'h10;
    localparam logic [7:0] ADDR_FORMAT = 8'h14;
    localparam logic [7:0] ADDR_DRIVE = 8'h15;
    localparam logic [7:0] ADDR_CLK_POL = 8'h16;
    localparam logic [7:0] ADDR_CLK_DELAY = 8'h17;
    localparam logic [7:0] ADDR_REF = 8'h18;
    localparam logic [7:0] ADDR_SIG_LSB = 8'h24;
    localparam logic [7:0] ADDR_SIG_MSB = 8'h25;

    // ****************************************************************
    // Values after reset
    // ****************************************************************
    localparam logic [7:0] RST_CHAN_INDEX = 8'hcf;
    localparam logic [7:0] RST_TEST = 8'h30;
    localparam logic [7:0] RST_SELF_TEST = 8'h00;
    localparam logic [7:0] RST_OFFSET = 8'h00;
    localparam logic [7:0] RST_FORMAT = 8'h00;
    localparam logic [7:0] RST_DRIVE = 8'h01;
    localparam logic [7:0] RST_CLK_POL = 8'h00;
    localparam logic [7:0] RST_CLK_DELAY = 8'h00;
    localparam logic [7:0] RST_REF = 8'h00;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int TEST_SEL_LSB = 0;
    localparam int LFSR_SHORT_RST_BIT = 4;
    localparam int LFSR_LONG_RST_BIT = 5;
    localparam int SELF_TEST_EN_BIT = 0;
    localparam int SELF_TEST_RST_BIT = 2;
    localparam int FMT_INVERT_BIT = 2;
    localparam int FMT_OE_B_BIT = 4;
    localparam int CLK_INV_BIT = 7;
    localparam int DELAY_EN_BIT = 7;

    // ****************************************************************
    // Output test selections and data formats
    // ****************************************************************
    localparam logic [2:0] TEST_OFF = 3'h0;
    localparam logic [2:0] TEST_MID = 3'h1;
    localparam logic [2:0] TEST_POS_FULL = 3'h2;
    localparam logic [2:0] TEST_NEG_FULL = 3'h3;
    localparam logic [2:0] TEST_CHECKER = 3'h4;
    localparam logic [2:0] TEST_LFSR_LONG = 3'h5;
    localparam logic [2:0] TEST_LFSR_SHORT = 3'h6;
    localparam logic [2:0] TEST_TOGGLE = 3'h7;
    localparam logic [1:0] FMT_OFFSET_BIN = 2'h0;
    localparam logic [1:0] FMT_TWOS = 2'h1;

    // ****************************************************************
    // Data path
    // ****************************************************************
    localparam int DATA_W = 11;
    localparam logic [10:0] WORD_MID = 11'h400;
    localparam logic [10:0] WORD_POS_FULL = 11'h7ff;
    localparam logic [10:0] WORD_NEG_FULL = 11'h000;
    localparam logic [10:0] WORD_CHECKER = 11'h555;
    localparam logic [22:0] LFSR_LONG_SEED = 23'h7fffff;
    localparam logic [8:0] LFSR_SHORT_SEED = 9'h1ff;

    // ****************************************************************
    // Output clock delay
    // ****************************************************************
    localparam logic [11:0] DELAY_STEP_PS = 12'h064;
    localparam logic [11:0] DELAY_MAX_PS = 12'hc80;

endpackage : aoc_pkg

// >>> design/aoc_output_test_config.sv
// Per-channel output test, format and output clock configuration bank.
//
// Behaviour
// - Three-bit test select per channel; code zero passes conversion data.
// - Codes 1 to 4 give midscale, plus full scale, minus full scale, checkerboard.
// - Code 101 outputs the long pseudo-random sequence.
// - Code 110 outputs the short pseudo-random sequence.
// - Code 111 alternates all ones and all zeros on successive samples.
// - Format field 00 gives offset binary, 01 gives twos complement.
// - Four-bit drive current per channel, reset code 0001, 0000 strongest.
// - Five-bit clock delay in 100 ps steps, code zero adds 100 ps.
// - Largest clock delay code adds 3.2 ns.
// - Per-channel writes land only on channels enabled in channel index.
`timescale 1ns/1ns
module aoc_output_test_config
    import aoc_pkg::*;
(
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst_b,
    // Register port from the serial port core, same clock.
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rd_valid,
    // Converter samples, offset binary.
    input wire logic [1:0][10:0] sample_in,
    // Output port data and controls.
    output logic [1:0][10:0] data_out,
    output logic [1:0] out_enable_b,
    output logic [1:0][3:0] drive_current,
    output logic [1:0] clk_invert,
    output logic clk_delay_en,
    output logic [11:0] clk_delay_ps,
    output logic [4:0] ref_adjust,
    output logic [1:0] self_test_active
);

    // ****************************************************************
    // Global registers
    // ****************************************************************
    logic [7:0] chan_index;
    logic [7:0] clk_delay_reg;
    logic [7:0] ref_reg;
    logic [7:0] test_reg [2];
    logic [7:0] self_test_reg [2];
    logic [7:0] offset_reg [2];
    logic [7:0] format_reg [2];
    logic [7:0] drive_reg [2];
    logic [7:0] clk_pol_reg [2];
    logic [15:0] signature [2];

    // Channel index and global registers ignore the channel enables.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            chan_index <= RST_CHAN_INDEX;
            clk_delay_reg <= RST_CLK_DELAY;
            ref_reg <= RST_REF;
        end else if (reg_wr) begin
            if (reg_addr == ADDR_CHAN_INDEX) chan_index <= reg_wdata;
            if (reg_addr == ADDR_CLK_DELAY) clk_delay_reg <= reg_wdata;
            if (reg_addr == ADDR_REF) ref_reg <= reg_wdata;
        end
    end

    // Delay in picoseconds is registered so the output is a clean flop.
    // linear delay steps
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            clk_delay_en <= RST_CLK_DELAY[DELAY_EN_BIT];
            clk_delay_ps <= DELAY_STEP_PS;
            ref_adjust <= RST_REF[4:0];
        end else begin
            clk_delay_en <= clk_delay_reg[DELAY_EN_BIT];
            clk_delay_ps <= 12'(({7'h00, clk_delay_reg[4:0]} + 12'h001) * DELAY_STEP_PS);
            ref_adjust <= ref_reg[4:0];
        end
    end

    // ****************************************************************
    // Per-channel logic
    // ****************************************************************
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_chan
            logic [22:0] lfsr_long;
            logic [8:0] lfsr_short;
            logic toggle;
            logic [10:0] trimmed;
            logic [10:0] next_word;
            logic [10:0] next_out;
            logic [2:0] test_sel;
            logic plain;
            logic chan_wr;

            assign test_sel = test_reg[ch][TEST_SEL_LSB +: 3];
            assign plain = (format_reg[ch][1:0] == FMT_OFFSET_BIN) &&
                !format_reg[ch][FMT_INVERT_BIT];
            assign chan_wr = reg_wr && chan_index[ch];

            // Local registers of this channel.
            // drive current reset
            always_ff @(posedge clk_sys or negedge rst_b) begin
                if (!rst_b) begin
                    test_reg[ch] <= RST_TEST;
                    self_test_reg[ch] <= RST_SELF_TEST;
                    offset_reg[ch] <= RST_OFFSET;
                    format_reg[ch] <= RST_FORMAT;
                    drive_reg[ch] <= RST_DRIVE;
                    clk_pol_reg[ch] <= RST_CLK_POL;
                end else if (chan_wr) begin
                    case (reg_addr)
                        ADDR_TEST: test_reg[ch] <= reg_wdata;
                        ADDR_SELF_TEST: self_test_reg[ch] <= reg_wdata;
                        ADDR_OFFSET: offset_reg[ch] <= reg_wdata;
                        ADDR_FORMAT: format_reg[ch] <= reg_wdata;
                        ADDR_DRIVE: drive_reg[ch] <= reg_wdata;
                        ADDR_CLK_POL: clk_pol_reg[ch] <= reg_wdata;
                        default: ;
                    endcase
                end
            end

            // Generators step whatever the pattern, unless their reset bits hold them at seed, so a pattern switch starts mid-sequence.
            // generator stepping
            always_ff @(posedge clk_sys or negedge rst_b) begin
                if (!rst_b) begin
                    lfsr_long <= LFSR_LONG_SEED;
                    lfsr_short <= LFSR_SHORT_SEED;
                    toggle <= 1'b0;
                end else begin
                    if (!test_reg[ch][LFSR_LONG_RST_BIT]) lfsr_long <= LFSR_LONG_SEED;
                    else lfsr_long <= {lfsr_long[21:0], lfsr_long[22] ^ lfsr_long[17]};
                    if (!test_reg[ch][LFSR_SHORT_RST_BIT]) lfsr_short <= LFSR_SHORT_SEED;
                    else lfsr_short <= {lfsr_short[7:0], lfsr_short[8] ^ lfsr_short[4]};
                    toggle <= ~toggle;
                end
            end

            // Offset trim wraps rather than saturates; trim range is small.
            assign trimmed = 11'(sample_in[ch] + {{5{offset_reg[ch][5]}}, offset_reg[ch][5:0]});

            // Pattern selection, then format and inversion on every source.
            // pattern select
            always_comb begin
                case (test_sel)
                    TEST_OFF: next_word = trimmed;
                    TEST_MID: next_word = WORD_MID;
                    TEST_POS_FULL: next_word = WORD_POS_FULL;
                    TEST_NEG_FULL: next_word = WORD_NEG_FULL;
                    TEST_CHECKER: next_word = toggle ? WORD_CHECKER : ~WORD_CHECKER;
                    TEST_LFSR_LONG: next_word = lfsr_long[10:0];
                    TEST_LFSR_SHORT: next_word = {lfsr_short[1:0], lfsr_short};
                    TEST_TOGGLE: next_word = toggle ? 11'h7ff : 11'h000;
                    default: next_word = trimmed;
                endcase
                next_out = next_word;
                if (format_reg[ch][1:0] == FMT_TWOS) next_out[10] = ~next_word[10];
                if (format_reg[ch][FMT_INVERT_BIT]) next_out = ~next_out;
            end

            // Output flops; the output clock path is untouched by test mode.
            always_ff @(posedge clk_sys or negedge rst_b) begin
                if (!rst_b) begin
                    data_out[ch] <= WORD_NEG_FULL;
                    out_enable_b[ch] <= RST_FORMAT[FMT_OE_B_BIT];
                    drive_current[ch] <= RST_DRIVE[3:0];
                    clk_invert[ch] <= RST_CLK_POL[CLK_INV_BIT];
                end else begin
                    data_out[ch] <= next_out;
                    out_enable_b[ch] <= format_reg[ch][FMT_OE_B_BIT];
                    drive_current[ch] <= drive_reg[ch][3:0];
                    clk_invert[ch] <= clk_pol_reg[ch][CLK_INV_BIT];
                end
            end

            // Signature folds the driven output words into a 16-bit register.
            // self-test run
            always_ff @(posedge clk_sys or negedge rst_b) begin
                if (!rst_b) begin
                    signature[ch] <= 16'h0000;
                    self_test_active[ch] <= 1'b0;
                end else begin
                    self_test_active[ch] <= self_test_reg[ch][SELF_TEST_EN_BIT] &&
                        self_test_reg[ch][SELF_TEST_RST_BIT];
                    if (!self_test_reg[ch][SELF_TEST_RST_BIT]) begin
                        signature[ch] <= 16'h0000;
                    end else if (self_test_reg[ch][SELF_TEST_EN_BIT]) begin
                        signature[ch] <= {signature[ch][14:0],
                            signature[ch][15] ^ signature[ch][4]} ^ {5'h00, data_out[ch]};
                    end
                end
            end

            // ********************************************************
            // Checks
            // ********************************************************
            property p_normal;
                @(posedge clk_sys) disable iff (!rst_b)
                (test_sel == TEST_OFF && plain) |=> data_out[ch] == $past(trimmed);
            endproperty
            a_normal: assert property (p_normal) else $error("Normal data not passed.");

            property p_mid;
                @(posedge clk_sys) disable iff (!rst_b)
                (test_sel == TEST_MID && plain) |=> data_out[ch] == 11'h400;
            endproperty
            a_mid: assert property (p_mid) else $error("Midscale pattern wrong.");

            property p_checker;
                @(posedge clk_sys) disable iff (!rst_b)
                (test_sel == TEST_CHECKER && plain) [*2] |=>
                    (data_out[ch] == ~$past(data_out[ch])) &&
                    (data_out[ch] == 11'h555 || data_out[ch] == 11'h2aa);
            endproperty
            a_checker: assert property (p_checker) else $error("Checkerboard wrong.");

            property p_lfsr_long;
                @(posedge clk_sys) disable iff (!rst_b)
                (test_sel == TEST_LFSR_LONG && plain) |=>
                    data_out[ch] == $past(lfsr_long[10:0]);
            endproperty
            a_lfsr_long: assert property (p_lfsr_long) else $error("Long sequence wrong.");

            property p_lfsr_short;
                @(posedge clk_sys) disable iff (!rst_b)
                (test_sel == TEST_LFSR_SHORT && plain) |=>
                    data_out[ch][8:0] == $past(lfsr_short);
            endproperty
            a_lfsr_short: assert property (p_lfsr_short) else $error("Short sequence wrong.");

            property p_toggle;
                @(posedge clk_sys) disable iff (!rst_b)
                (test_sel == TEST_TOGGLE && plain) [*2] |=>
                    (data_out[ch] == 11'h7ff || data_out[ch] == 11'h000) &&
                    data_out[ch] == ~$past(data_out[ch]);
            endproperty
            a_toggle: assert property (p_toggle) else $error("Word toggle wrong.");

            property p_twos;
                @(posedge clk_sys) disable iff (!rst_b)
                (test_sel == TEST_POS_FULL && format_reg[ch][1:0] == FMT_TWOS &&
                    !format_reg[ch][FMT_INVERT_BIT]) |=> data_out[ch] == 11'h3ff;
            endproperty
            a_twos: assert property (p_twos) else $error("Twos complement wrong.");

            property p_gate;
                @(posedge clk_sys) disable iff (!rst_b)
                (reg_wr && reg_addr == ADDR_DRIVE && !chan_index[ch]) |=>
                    $stable(drive_reg[ch]) ##1 drive_current[ch] == $past(drive_current[ch]);
            endproperty
            a_gate: assert property (p_gate) else $error("Unselected channel written.");

            property p_self_test;
                @(posedge clk_sys) disable iff (!rst_b)
                !self_test_reg[ch][SELF_TEST_RST_BIT] |=>
                    signature[ch] == 16'h0000 && !self_test_active[ch];
            endproperty
            a_self_test: assert property (p_self_test) else $error("Self-test not reset.");
        end
    endgenerate

    property p_delay_max;
        @(posedge clk_sys) disable iff (!rst_b)
        clk_delay_reg[4:0] == 5'h1f |=> clk_delay_ps == 12'hc80;
    endproperty
    a_delay_max: assert property (p_delay_max) else $error("Max delay not 3.2 ns.");

    property p_delay_min;
        @(posedge clk_sys) disable iff (!rst_b)
        clk_delay_reg[4:0] == 5'h00 |=> clk_delay_ps == 12'h064;
    endproperty
    a_delay_min: assert property (p_delay_min) else $error("Min delay not 100 ps.");

    property p_drive_reset;
        @(posedge clk_sys) disable iff (!rst_b)
        $rose(rst_b) |-> drive_current[0] == 4'h1 && drive_current[1] == 4'h1;
    endproperty
    a_drive_reset: assert property (p_drive_reset) else $error("Drive reset wrong.");

    // ****************************************************************
    // Register read-back
    // ****************************************************************
    // Local reads show channel A when it is enabled, otherwise channel B.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= 8'h00;
            reg_rd_valid <= 1'b0;
        end else begin
            reg_rd_valid <= reg_rd;
            if (reg_rd) begin
                case (reg_addr)
                    ADDR_CHAN_INDEX: reg_rdata <= chan_index;
                    ADDR_CLK_DELAY: reg_rdata <= clk_delay_reg;
                    ADDR_REF: reg_rdata <= ref_reg;
                    ADDR_TEST: reg_rdata <= test_reg[!chan_index[0]];
                    ADDR_SELF_TEST: reg_rdata <= self_test_reg[!chan_index[0]];
                    ADDR_OFFSET: reg_rdata <= offset_reg[!chan_index[0]];
                    ADDR_FORMAT: reg_rdata <= format_reg[!chan_index[0]];
                    ADDR_DRIVE: reg_rdata <= drive_reg[!chan_index[0]];
                    ADDR_CLK_POL: reg_rdata <= clk_pol_reg[!chan_index[0]];
                    ADDR_SIG_LSB: reg_rdata <= signature[!chan_index[0]][7:0];
                    ADDR_SIG_MSB: reg_rdata <= signature[!chan_index[0]][15:8];
                    default: reg_rdata <= 8'h00;
                endcase
            end
        end
    end

endmodule : aoc_output_test_config

// >>> verification/aoc_host_model.sv
// Serial port host model that issues register writes and reads.
`timescale 1ns/1ns
module aoc_host_model (
    // Clock.
    input wire logic clk_sys,
    // Register port toward the bank.
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rd_valid
);
    // Idle bus at time zero.
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end

    // One write; released lines show the inverse so stale values never pass.
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clk_sys);
        #1;
        reg_wr = 1'b1;
        reg_addr = addr;
        reg_wdata = data;
        @(posedge clk_sys);
        #1;
        reg_wr = 1'b0;
        reg_addr = ~addr;
        reg_wdata = ~data;
    endtask : wr

    // One read; the answer is taken one edge after the request.
    task automatic rd(input logic [7:0] addr, output logic [7:0] data, output logic ok);
        @(posedge clk_sys);
        #1;
        reg_rd = 1'b1;
        reg_addr = addr;
        @(posedge clk_sys);
        #1;
        ok = reg_rd_valid;
        data = reg_rdata;
        reg_rd = 1'b0;
        reg_addr = ~addr;
    endtask : rd
endmodule : aoc_host_model

// >>> verification/tb_top.sv
// Self-checking testbench for the output test and configuration bank.
`timescale 1ns/1ns
module tb_top;
    import aoc_pkg::*;
    // ****************************************************************
    // Signals and instances
    // ****************************************************************
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic reg_wr, reg_rd, reg_rd_valid;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [1:0][10:0] sample_in = {2{11'h123}};
    logic [1:0][10:0] data_out;
    logic [1:0] out_enable_b, clk_invert, self_test_active;
    logic [1:0][3:0] drive_current;
    logic clk_delay_en;
    logic [11:0] clk_delay_ps;
    logic [4:0] ref_adjust;
    int fails = 0;
    int samples_checked = 0;

    // The clock runs at 10 MHz.
    always #50 clk_sys = ~clk_sys;

    aoc_output_test_config i_aoc_output_test_config (.clk_sys(clk_sys), .rst_b(rst_b),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid), .sample_in(sample_in),
        .data_out(data_out), .out_enable_b(out_enable_b), .drive_current(drive_current),
        .clk_invert(clk_invert), .clk_delay_en(clk_delay_en), .clk_delay_ps(clk_delay_ps),
        .ref_adjust(ref_adjust), .self_test_active(self_test_active));
    aoc_host_model i_aoc_host_model (.clk_sys(clk_sys), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rd_valid(reg_rd_valid));

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    // Compares any output value, zero extended to twelve bits.
    task automatic cmp_val(input logic [11:0] got, input logic [11:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : cmp_val

    // Reads a register and compares data and the valid pulse.
    task automatic cmp_reg(input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] data;
        logic ok;
        i_aoc_host_model.rd(addr, data, ok);
        cmp_val({11'h0, ok}, 12'h001, "read valid");
        cmp_val({4'h0, data}, {4'h0, exp}, "read data");
    endtask : cmp_reg

    // Writes, then lets the two edges pass after which outputs follow.
    task automatic wr_settle(input logic [7:0] addr, input logic [7:0] data);
        i_aoc_host_model.wr(addr, data);
        repeat (2) @(posedge clk_sys);
        #1;
    endtask : wr_settle

    // Takes two successive output words of channel A.
    task automatic two_words(output logic [10:0] a, output logic [10:0] b);
        a = data_out[0];
        @(posedge clk_sys);
        #1;
        b = data_out[0];
    endtask : two_words

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    // Reset values, an unmapped read and the derived outputs.
    task automatic test_reset_values;
        cmp_reg(ADDR_DRIVE, 8'h01);
        cmp_reg(ADDR_TEST, RST_TEST);
        cmp_reg(ADDR_SELF_TEST, 8'h00);
        cmp_reg(ADDR_CHAN_INDEX, 8'hcf);
        cmp_reg(8'h30, 8'h00);
        cmp_val({4'h0, drive_current}, 12'h011, "drive reset");
        cmp_val(clk_delay_ps, 12'h064, "delay reset");
    endtask : test_reset_values

    // Normal data, offset trim, format, invert and output enable.
    task automatic test_data_format;
        cmp_val({1'b0, data_out[0]}, 12'h123, "normal data");
        wr_settle(ADDR_OFFSET, 8'h01);
        cmp_val({1'b0, data_out[1]}, 12'h124, "trim plus one");
        wr_settle(ADDR_OFFSET, 8'h00);
        wr_settle(ADDR_FORMAT, 8'h01);
        cmp_val({1'b0, data_out[0]}, 12'h523, "twos format");
        wr_settle(ADDR_FORMAT, 8'h05);
        cmp_val({1'b0, data_out[0]}, 12'h2dc, "inverted");
        wr_settle(ADDR_FORMAT, 8'h10);
        cmp_val({10'h0, out_enable_b}, 12'h003, "outputs off");
        cmp_val({1'b0, data_out[0]}, 12'h123, "offset binary");
        wr_settle(ADDR_FORMAT, 8'h00);
    endtask : test_data_format

    // Fixed patterns, checkerboard and word toggle.
    task automatic test_patterns;
        logic [10:0] a, b;
        logic [10:0] exp [3] = '{11'h400, 11'h7ff, 11'h000};
        for (int i = 0; i < 3; i++) begin
            wr_settle(ADDR_TEST, 8'h31 + 8'(i));
            cmp_val({1'b0, data_out[0]}, {1'b0, exp[i]}, "fixed pattern");
            cmp_val({10'h0, clk_invert}, 12'h000, "clock kept");
        end
        // Twos complement applies to test words as well as samples.
        wr_settle(ADDR_TEST, 8'h32);
        wr_settle(ADDR_FORMAT, 8'h01);
        cmp_val({1'b0, data_out[0]}, 12'h3ff, "twos full scale");
        wr_settle(ADDR_FORMAT, 8'h00);
        wr_settle(ADDR_TEST, 8'h34);
        two_words(a, b);
        cmp_val({1'b0, a ^ b}, 12'h7ff, "checker swap");
        cmp_val({11'h0, a == 11'h555 || a == 11'h2aa}, 12'h001, "checker");
        wr_settle(ADDR_TEST, 8'h37);
        two_words(a, b);
        cmp_val({1'b0, a ^ b}, 12'h7ff, "toggle swap");
        cmp_val({11'h0, a == 11'h7ff || a == 11'h000}, 12'h001, "toggle");
    endtask : test_patterns

    // Pseudo-random sequences: seed while held, moving once released.
    task automatic test_prbs;
        logic [10:0] a, b, c;
        logic [7:0] hold [2] = '{8'h05, 8'h06};
        logic [7:0] run [2] = '{8'h25, 8'h16};
        for (int i = 0; i < 2; i++) begin
            wr_settle(ADDR_TEST, hold[i]);
            two_words(a, b);
            cmp_val({1'b0, a & b}, 12'h7ff, "seed held");
            wr_settle(ADDR_TEST, run[i]);
            two_words(a, b);
            two_words(b, c);
            cmp_val({11'h0, a != b || b != c}, 12'h001, "sequence runs");
        end
        wr_settle(ADDR_TEST, RST_TEST);
    endtask : test_prbs

    // Drive current, clock polarity, delay range and reference adjust.
    task automatic test_port_controls;
        wr_settle(ADDR_DRIVE, 8'h00);
        cmp_val({4'h0, drive_current}, 12'h000, "drive max");
        wr_settle(ADDR_CLK_POL, 8'h80);
        cmp_val({10'h0, clk_invert}, 12'h003, "clock invert");
        wr_settle(ADDR_CLK_DELAY, 8'h80);
        cmp_val({clk_delay_en, clk_delay_ps[10:0]}, 12'h864, "delay min");
        cmp_val(clk_delay_ps, 12'h064, "delay step");
        wr_settle(ADDR_CLK_DELAY, 8'h9f);
        cmp_val(clk_delay_ps, 12'hc80, "delay max");
        wr_settle(ADDR_REF, 8'h1f);
        cmp_val({7'h0, ref_adjust}, 12'h01f, "reference");
    endtask : test_port_controls

    // Channel index gates local writes and selects the read channel.
    task automatic test_chan_index;
        wr_settle(ADDR_CHAN_INDEX, 8'h02);
        wr_settle(ADDR_DRIVE, 8'h05);
        cmp_val({4'h0, drive_current}, 12'h050, "only B written");
        cmp_reg(ADDR_DRIVE, 8'h05);
        wr_settle(ADDR_CHAN_INDEX, 8'h01);
        cmp_reg(ADDR_DRIVE, 8'h00);
        wr_settle(ADDR_CHAN_INDEX, 8'hcf);
    endtask : test_chan_index

    // Self-test runs only with its reset released and enable set.
    task automatic test_self_test;
        wr_settle(ADDR_SELF_TEST, 8'h01);
        cmp_val({10'h0, self_test_active}, 12'h000, "held in reset");
        cmp_reg(ADDR_SIG_LSB, 8'h00);
        wr_settle(ADDR_SELF_TEST, 8'h05);
        cmp_val({10'h0, self_test_active}, 12'h003, "self-test on");
        wr_settle(ADDR_SELF_TEST, 8'h00);
    endtask : test_self_test

    // ****************************************************************
    // Sequence, verdict and watchdog
    // ****************************************************************
    // Prints the counts and the verdict, then ends the run.
    task automatic print_verdict;
        $display("checks %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : print_verdict

    // Main sequence after twenty cycles of reset.
    initial begin
        repeat (20) @(posedge clk_sys);
        #1;
        rst_b = 1'b1;
        test_reset_values();
        test_data_format();
        test_patterns();
        test_prbs();
        test_port_controls();
        test_chan_index();
        test_self_test();
        print_verdict();
    end

    // The whole run needs well under a thousand cycles.
    initial begin
        repeat (5000) @(posedge clk_sys);
        fails++;
        print_verdict();
    end
endmodule : tb_top
